// ---- include/phy_timing_pkg.sv ----
// Shared timing counts, states and carriers for the MII frame timing core.
// Assumes one 40 MHz core clock; every pin is synchronised inside the core.
// Notes on behaviour
// - Port enable rise drives receive outputs two clocks later.
// - Port enable fall: outputs low, then float; the core forces only receive clock, valid and error low, not the data nibble.
// - Frame starts on medium 10-12 / 3.5-5 bits.
// - Transmit raises carrier sense within 4 / 1.5 bits.
// - Frame ends 17/5 bits, carrier drops 11/6.
// - Ten-megabit end of frame high 250-350 ns.
// - Heartbeat begins 7-8 bits after transmit end.
// - Heartbeat holds collision for 9-11 bits.
// - Transmit enable held 26 ms engages jabber cutoff.
// - Jabber holds collision 410 ms after enable drops.
// - Receive carrier sense rises 11-13 / 3-5 bits.
// - Receive valid rises within 15 / 22 bits.
// - Receive carrier sense falls 14-16 / 4.5 bits.
// - Receive valid falls within 12 / 4 bits.
// - Link pulses 100 ns wide, 8-24 ms apart.
// - Negotiation clock pulses 125 us, data 62.5 us.
// - Bursts of 17-33 pulses every 8-24 ms.
package phy_timing_pkg;

	// ------------------------------------------------------------
	// Clock and bit times
	// ------------------------------------------------------------
	localparam int CLK_MHZ   = 40;
	localparam int CLK_NS    = 1000 / CLK_MHZ;
	localparam int BIT100_NS = 10;
	localparam int BIT10_NS  = 100;

	// Least times round up, longest times round down, never below one cycle.
	function automatic int cycUp(input int ns);
		return (ns < CLK_NS) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
	endfunction : cycUp

	function automatic int cycDn(input int ns);
		return (ns < CLK_NS) ? 1 : ns / CLK_NS;
	endfunction : cycDn

	// ------------------------------------------------------------
	// Frame timing counts
	// ------------------------------------------------------------
	localparam int TXST100_CYC    = cycUp(10 * BIT100_NS);
	localparam int TXST10_CYC     = cycUp(35 * BIT10_NS / 10);
	localparam int CRSON100_CYC   = cycDn(4 * BIT100_NS);
	localparam int CRSON10_CYC    = cycDn(15 * BIT10_NS / 10);
	localparam int TXEND100_CYC   = cycDn(17 * BIT100_NS);
	localparam int TXEND10_CYC    = cycDn(5 * BIT10_NS);
	localparam int CRSOFF100_CYC  = cycDn(11 * BIT100_NS);
	localparam int CRSOFF10_CYC   = cycDn(6 * BIT10_NS);
	localparam int EOF_MIN_NS     = 250;
	localparam int EOF_CYC        = cycUp(EOF_MIN_NS);
	localparam int HBDEL_CYC      = cycUp(7 * BIT10_NS);
	localparam int HBDUR_CYC      = cycUp(9 * BIT10_NS);
	localparam int RXCRSON100_CYC = cycUp(11 * BIT100_NS);
	localparam int RXCRSON10_CYC  = cycUp(3 * BIT10_NS);
	localparam int RXDVON100_CYC  = cycDn(15 * BIT100_NS);
	localparam int RXDVON10_CYC   = cycDn(22 * BIT10_NS);
	localparam int RXCRSOF100_CYC = cycUp(14 * BIT100_NS);
	localparam int RXCRSOF10_CYC  = cycDn(45 * BIT10_NS / 10);
	localparam int RXDVOFF100_CYC = cycDn(12 * BIT100_NS);
	localparam int RXDVOFF10_CYC  = cycDn(4 * BIT10_NS);
	localparam logic [1:0] PORT_EDGES = 2'h2;

	// ------------------------------------------------------------
	// Link pulse and jabber timing
	// ------------------------------------------------------------
	localparam int PULSE_NS      = 100;
	localparam int PULSE_CYC     = cycDn(PULSE_NS);
	localparam int NLP_MIN_MS    = 8;
	localparam int NLP_MAX_MS    = 24;
	localparam int NLP_PER_CYC   = (NLP_MIN_MS + NLP_MAX_MS) / 2 * 1000000 / CLK_NS;
	localparam int FLP_DAT_NS    = 62500;
	localparam int FLP_HALF_CYC  = cycDn(FLP_DAT_NS);
	localparam logic [5:0] FLP_LAST_SLOT = 6'h20;
	localparam int JAB_ON_MS     = 26;
	localparam int JAB_ON_CYC    = JAB_ON_MS * 1000000 / CLK_NS;
	localparam int JAB_OFF_MS    = 410;
	localparam int JAB_OFF_CYC   = JAB_OFF_MS * 1000000 / CLK_NS;

	// ------------------------------------------------------------
	// States and carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_LEAD = 3'h1,
		TX_SEND = 3'h3,
		TX_TAIL = 3'h2,
		TX_EOF  = 3'h6,
		TX_HBD  = 3'h7,
		TX_HB   = 3'h5
	} txState_e;

	typedef struct packed {
		logic       clk;
		logic [3:0] data;
		logic       dv;
		logic       er;
	} rxMii_s;

	typedef struct packed {
		logic [3:0] txData;
		logic       receive_port_enable;
		logic       carrier;
		logic       txEn;
		logic       txClk;
	} pinIn_s;

	function automatic logic [7:0] pick(input logic fast, input int a, input int b);
		return fast ? 8'(a) : 8'(b);
	endfunction : pick

endpackage : phy_timing_pkg

// ---- core/two_entry_buffer.sv ----
// Two-entry valid/ready buffer on the transmit nibble path.
// Assumes both sides run on the core clock.
`timescale 1ns/1ps
module two_entry_buffer #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  logic             clk,
	input  logic             rst,
	// Fill side
	input  logic             inValid,
	input  logic [WIDTH-1:0] inData,
	output logic             inReady,
	// Drain side
	output logic             outValid,
	output logic [WIDTH-1:0] outData,
	input  logic             outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_q;
	logic [PW-1:0]    rdPtr_q;
	logic [PW:0]      count_q;
	logic             push;
	logic             pop;

	function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction : nextPtr

	assign inReady  = (count_q != (PW + 1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData  = mem[rdPtr_q];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wrPtr_q] <= inData;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wrPtr_q <= nextPtr(wrPtr_q);
			if (pop)
				rdPtr_q <= nextPtr(rdPtr_q);
			if (push && !pop)
				count_q <= count_q + (PW + 1)'(1);
			else if (pop && !push)
				count_q <= count_q - (PW + 1)'(1);
		end
	end

	a_buf_hold: assert property (@(posedge clk) disable iff (rst)
		outValid && !outReady |=> outValid && $stable(outData))
		else $error("buffered word changed or vanished while stalled");
	a_buf_full: assert property (@(posedge clk) disable iff (rst)
		!inReady |-> outValid && $past(inValid || !inReady))
		else $error("buffer refused a word while not holding two");

endmodule : two_entry_buffer

// ---- core/phy_frame_timing.sv ----
// MII frame timing core: transmit/receive latencies, carrier sense, heartbeat,
// jabber, repeater port enable and link pulse generation.
// Assumes clk is the 25 MHz-class reference scaled to 40 MHz and pins are asynchronous.
`timescale 1ns/1ps
module phy_frame_timing #(
	parameter int NLP_PERIOD_CYC = phy_timing_pkg::NLP_PER_CYC,
	parameter int JAB_ON         = phy_timing_pkg::JAB_ON_CYC,
	parameter int JAB_OFF        = phy_timing_pkg::JAB_OFF_CYC
) (
	// Clock and reset
	input  logic                   clk,
	input  logic                   rst,
	// Configuration
	input  logic                   speed100,
	input  logic                   repeaterMode,
	input  logic                   autoNegEn,
	input  logic [15:0]            anWord,
	// MII pins from the controller
	input  phy_timing_pkg::pinIn_s pins,
	// Receive decoder, core clock domain
	input  logic [3:0]             rxNibble,
	input  logic                   rxErrIn,
	// MII outputs
	output phy_timing_pkg::rxMii_s rxOut,
	output phy_timing_pkg::rxMii_s rxOe,
	output logic                   crs,
	output logic                   col,
	output logic                   txAccept,
	// Medium side
	output logic                   mediumActive,
	output logic                   mediumEof,
	output logic [3:0]             mediumData,
	output logic                   mediumValid,
	input  logic                   mediumReady,
	output logic                   linkPulse
);
	import phy_timing_pkg::*;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	pinIn_s     s1_q;
	pinIn_s     s2_q;
	pinIn_s     s3_q;
	pinIn_s     lvl_q;
	pinIn_s     prev_q;
	txState_e   txState_q;
	logic [7:0] txCnt_q;
	logic       mediumActive_q;
	logic       eofHigh_q;
	logic       hbCol_q;
	logic [24:0] jabCnt_q;
	logic       jabber_q;
	logic [2:0] dlyLoad;
	logic [2:0] dlyLvl;
	logic [7:0] dlyLen [3];
	logic [2:0] dlyTgt_q;
	logic [2:0] dlyOut_q;
	logic [7:0] dlyCnt_q [3];
	logic [1:0] portCnt_q;
	logic       drive_q;
	logic       lowForce_q;
	rxMii_s     rxOut_q;
	logic       col_q;
	logic [19:0] perCnt_q;
	logic [11:0] halfCnt_q;
	logic [5:0] slot_q;
	logic       burst_q;
	logic [2:0] pulseCnt_q;
	logic       linkPulse_q;
	logic       txcRise;
	logic       txStartEv;
	logic       txEndEv;
	logic       crsTxEndEv;
	logic       rxStartEv;
	logic       rxEndEv;
	logic       txPush;
	logic [7:0] hbLen_q;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	// A level is accepted only once the second and third stages agree,
	// which filters a single-cycle glitch on slow link pins.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			lvl_q  <= '0;
			prev_q <= '0;
		end
		else
		begin
			s1_q   <= pins;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			lvl_q  <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
			prev_q <= lvl_q;
		end
	end

	assign txcRise    = lvl_q.txClk & ~prev_q.txClk;
	assign txStartEv  = txcRise & lvl_q.txEn & (txState_q == TX_IDLE) & ~jabber_q;
	assign txEndEv    = txcRise & ~lvl_q.txEn & (txState_q == TX_SEND);
	assign crsTxEndEv = txcRise & ~lvl_q.txEn & dlyTgt_q[0];
	assign rxStartEv  = lvl_q.carrier & ~prev_q.carrier;
	assign rxEndEv    = ~lvl_q.carrier & prev_q.carrier;

	// ------------------------------------------------------------
	// Transmit frame sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			txState_q      <= TX_IDLE;
			txCnt_q        <= 8'h00;
			mediumActive_q <= 1'b0;
			eofHigh_q      <= 1'b0;
			hbCol_q        <= 1'b0;
		end
		else
		begin
			if (txCnt_q != 8'h00)
				txCnt_q <= txCnt_q - 8'h01;
			case (txState_q)
				TX_IDLE:
					if (txStartEv)
					begin
						txState_q <= TX_LEAD;
						txCnt_q   <= pick(speed100, TXST100_CYC, TXST10_CYC) - 8'h01;
					end
				TX_LEAD:
					if (txCnt_q == 8'h00)
					begin
						txState_q      <= TX_SEND;
						mediumActive_q <= 1'b1;
					end
				TX_SEND:
					if (jabber_q)
					begin
						txState_q      <= TX_IDLE;
						mediumActive_q <= 1'b0;
					end
					else if (txEndEv)
					begin
						txState_q <= TX_TAIL;
						txCnt_q   <= pick(speed100, TXEND100_CYC, TXEND10_CYC) - 8'h01;
					end
				TX_TAIL:
					if (txCnt_q == 8'h00)
					begin
						mediumActive_q <= 1'b0;
						if (speed100)
							txState_q <= TX_IDLE;
						else
						begin
							txState_q <= TX_EOF;
							eofHigh_q <= 1'b1;
							txCnt_q   <= 8'(EOF_CYC - 1);
						end
					end
				TX_EOF:
					if (txCnt_q == 8'h00)
					begin
						eofHigh_q <= 1'b0;
						txState_q <= TX_HBD;
						txCnt_q   <= 8'(HBDEL_CYC - 1);
					end
				TX_HBD:
					if (txCnt_q == 8'h00)
					begin
						hbCol_q   <= 1'b1;
						txState_q <= TX_HB;
						txCnt_q   <= 8'(HBDUR_CYC - 1);
					end
				TX_HB:
					if (txCnt_q == 8'h00)
					begin
						hbCol_q   <= 1'b0;
						txState_q <= TX_IDLE;
					end
				default:
				begin
					txState_q      <= TX_IDLE;
					mediumActive_q <= 1'b0;
					eofHigh_q      <= 1'b0;
					hbCol_q        <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Jabber guard
	// ------------------------------------------------------------
	// Timed on the core clock so the window is exact whatever the link does.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			jabCnt_q <= '0;
			jabber_q <= 1'b0;
		end
		else if (!jabber_q)
		begin
			if (!lvl_q.txEn || speed100)
				jabCnt_q <= '0;
			else if (jabCnt_q == 25'(JAB_ON - 1))
			begin
				jabber_q <= 1'b1;
				jabCnt_q <= '0;
			end
			else
				jabCnt_q <= jabCnt_q + 25'h1;
		end
		else if (lvl_q.txEn)
			jabCnt_q <= '0;
		else if (jabCnt_q == 25'(JAB_OFF - 1))
		begin
			jabber_q <= 1'b0;
			jabCnt_q <= '0;
		end
		else
			jabCnt_q <= jabCnt_q + 25'h1;
	end

	// ------------------------------------------------------------
	// Carrier sense and receive valid delays
	// ------------------------------------------------------------
	// Channel 0 is transmit carrier, 1 is receive carrier, 2 is receive valid.
	always_comb
	begin
		dlyLoad   = {rxStartEv | rxEndEv, rxStartEv | rxEndEv, txStartEv | crsTxEndEv};
		dlyLvl    = {rxStartEv, rxStartEv, txStartEv};
		dlyLen[0] = txStartEv ? pick(speed100, CRSON100_CYC, CRSON10_CYC)
			: pick(speed100, CRSOFF100_CYC, CRSOFF10_CYC);
		dlyLen[1] = rxStartEv ? pick(speed100, RXCRSON100_CYC, RXCRSON10_CYC)
			: pick(speed100, RXCRSOF100_CYC, RXCRSOF10_CYC);
		dlyLen[2] = rxStartEv ? pick(speed100, RXDVON100_CYC, RXDVON10_CYC)
			: pick(speed100, RXDVOFF100_CYC, RXDVOFF10_CYC);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dlyTgt_q <= 3'h0;
			dlyOut_q <= 3'h0;
			for (int i = 0; i < 3; i++)
				dlyCnt_q[i] <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (dlyLoad[i])
				begin
					dlyTgt_q[i] <= dlyLvl[i];
					dlyCnt_q[i] <= dlyLen[i] - 8'h01;
				end
				else if (dlyCnt_q[i] != 8'h00)
					dlyCnt_q[i] <= dlyCnt_q[i] - 8'h01;
				else
					dlyOut_q[i] <= dlyTgt_q[i];
			end
		end
	end

	assign crs = dlyOut_q[0] | dlyOut_q[1];

	// ------------------------------------------------------------
	// Repeater port enable
	// ------------------------------------------------------------
	// The receive clock is the synchronised link clock, so its edges pace this.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			portCnt_q  <= PORT_EDGES;
			drive_q    <= 1'b0;
			lowForce_q <= 1'b1;
		end
		else if (lvl_q.receive_port_enable != prev_q.receive_port_enable)
			portCnt_q <= 2'h0;
		else if (txcRise && portCnt_q != PORT_EDGES)
		begin
			portCnt_q <= portCnt_q + 2'h1;
			if (portCnt_q == PORT_EDGES - 2'h1)
				drive_q <= lvl_q.receive_port_enable;
			else
				lowForce_q <= ~lvl_q.receive_port_enable;
		end
	end

	assign rxOe = repeaterMode ? {7{drive_q}} : '1;

	// ------------------------------------------------------------
	// MII output registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rxOut_q <= '0;
			col_q   <= 1'b0;
		end
		else
		begin
			// Forcing low only matters where the port can float; outside repeater mode the outputs always run.
			rxOut_q.clk  <= lvl_q.txClk & ~(lowForce_q & repeaterMode);
			rxOut_q.dv   <= dlyOut_q[2] & ~(lowForce_q & repeaterMode);
			rxOut_q.er   <= dlyOut_q[2] & rxErrIn & ~(lowForce_q & repeaterMode);
			rxOut_q.data <= dlyOut_q[2] ? rxNibble : 4'h0;
			col_q        <= hbCol_q | jabber_q | (dlyOut_q[0] & dlyOut_q[1]);
		end
	end

	assign rxOut        = rxOut_q;
	assign col          = col_q;
	assign mediumActive = mediumActive_q;
	assign mediumEof    = eofHigh_q;
	assign linkPulse    = linkPulse_q;

	// ------------------------------------------------------------
	// Transmit nibble buffer
	// ------------------------------------------------------------
	// A stalled medium fills the buffer; txAccept then tells the controller.
	assign txPush = txcRise & lvl_q.txEn & ~jabber_q
		& (txState_q == TX_IDLE || txState_q == TX_LEAD || txState_q == TX_SEND);

	two_entry_buffer #(
		.WIDTH (4),
		.DEPTH (2)
	) uTxBuf (
		.clk      (clk),
		.rst      (rst),
		.inValid  (txPush),
		.inData   (lvl_q.txData),
		.inReady  (txAccept),
		.outValid (mediumValid),
		.outData  (mediumData),
		.outReady (mediumReady)
	);

	// ------------------------------------------------------------
	// Link pulses and negotiation bursts
	// ------------------------------------------------------------
	// Even slots carry clock pulses, odd slots carry data bits of anWord.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			perCnt_q    <= '0;
			halfCnt_q   <= '0;
			slot_q      <= '0;
			burst_q     <= 1'b0;
			pulseCnt_q  <= 3'h0;
			linkPulse_q <= 1'b0;
		end
		else
		begin
			linkPulse_q <= (pulseCnt_q != 3'h0);
			if (pulseCnt_q != 3'h0)
				pulseCnt_q <= pulseCnt_q - 3'h1;
			if (perCnt_q != 20'h0)
				perCnt_q <= perCnt_q - 20'h1;
			else
			begin
				perCnt_q <= 20'(NLP_PERIOD_CYC - 1);
				if (autoNegEn)
				begin
					burst_q   <= 1'b1;
					slot_q    <= '0;
					halfCnt_q <= '0;
				end
				else if (!speed100 && !mediumActive_q)
					pulseCnt_q <= 3'(PULSE_CYC);
			end
			if (burst_q)
			begin
				if (halfCnt_q != 12'h0)
					halfCnt_q <= halfCnt_q - 12'h1;
				else
				begin
					halfCnt_q <= 12'(FLP_HALF_CYC - 1);
					if (!slot_q[0] || anWord[slot_q[4:1]])
						pulseCnt_q <= 3'(PULSE_CYC);
					if (slot_q == FLP_LAST_SLOT)
						burst_q <= 1'b0;
					else
						slot_q <= slot_q + 6'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hbLen_q <= 8'h00;
		else
			hbLen_q <= hbCol_q ? hbLen_q + 8'h01 : 8'h00;
	end

	a_port_drive: assert property ($rose(drive_q) |-> lvl_q.receive_port_enable && $past(txcRise))
		else $error("receive outputs driven without port enable edge");
	a_port_low: assert property ($fell(drive_q) && repeaterMode |-> !rxOut_q.clk && !rxOut_q.dv && !rxOut_q.er)
		else $error("receive outputs floated before being driven low");
	a_tx_start: assert property (txStartEv && !speed100 |-> ##1 !mediumActive_q[*8] ##7 mediumActive_q)
		else $error("frame start delay wrong at 10 Mbps");
	a_crs_tx: assert property (txStartEv && !speed100 |-> !dlyOut_q[0][*7] ##1 dlyOut_q[0])
		else $error("transmit carrier sense delay wrong");
	a_tx_end: assert property (txEndEv && speed100 |-> ##[1:7] !mediumActive_q)
		else $error("frame end too late at 100 Mbps");
	a_eof_width: assert property ($rose(eofHigh_q) |-> eofHigh_q[*8] ##1 eofHigh_q[*2] ##1 !eofHigh_q)
		else $error("end of frame high time wrong");
	a_hb_delay: assert property ($fell(eofHigh_q) |-> !hbCol_q[*8] ##21 hbCol_q)
		else $error("heartbeat delay wrong");
	a_hb_width: assert property ($fell(hbCol_q) |-> hbLen_q == 8'(HBDUR_CYC))
		else $error("heartbeat duration wrong");
	a_jab_cut: assert property ($rose(jabber_q) |-> ##[0:1] !mediumActive_q)
		else $error("jabber did not cut the frame");
	a_rx_crs: assert property (rxStartEv && speed100 |-> ##6 crs)
		else $error("receive carrier sense late");
	a_rx_dv_off: assert property (rxEndEv && !speed100 |-> ##18 !rxOut_q.dv)
		else $error("receive valid held too long");
	a_link_width: assert property ($rose(linkPulse_q) |-> linkPulse_q[*4] ##1 !linkPulse_q)
		else $error("link pulse width wrong");

	c_frame: cover property (txStartEv ##[1:200] $fell(mediumActive_q));
	c_heartbeat: cover property ($rose(hbCol_q));
	c_jabber: cover property ($fell(jabber_q));
	c_burst: cover property ($fell(burst_q));

endmodule : phy_frame_timing

// ---- sim/mii_mac_model.sv ----
// Controller model: makes the link clock and sends one nibble frame on request.
// Assumes the bench asks for a frame through len and keeps the clock running through clkOn.
`timescale 1ns/1ps
module mii_mac_model (
	// Bench control
	input  wire logic       clkOn,
	input  wire logic [7:0] len,
	// Transmit pins
	output logic            txClk,
	output logic            txEn,
	output logic [3:0]      txData
);
	logic [7:0] left;

	// ----------------------------------------
	// Link clock and nibble stream
	// ----------------------------------------
	// The clock stands still while clkOn is low, but its edges keep a 100 ns grid, so its phase to the core clock is fixed.
	initial
	begin
		txClk = 1'b0;
		txEn = 1'b0;
		txData = 4'h0;
		left = 8'h0;
		#7;
		forever
		begin
			#100;
			if (clkOn || txClk)
				txClk = ~txClk;
		end
	end

	// Pins change on the falling edge so they are steady around each rising edge.
	always @(negedge txClk)
	begin
		if (left != 8'h0)
		begin
			txEn <= 1'b1;
			txData <= txData + 4'h1;
			left <= left - 8'h1;
		end
		else if (!txEn && len != 8'h0)
		begin
			left <= len;
			txData <= 4'h0;
		end
		else
		begin
			txEn <= 1'b0;
			txData <= ~txData;
		end
	end
endmodule : mii_mac_model

// ---- sim/phy_frame_timing_tb.sv ----
// Bench for the frame timing core: transmit, receive, heartbeat, jabber, port enable, link pulses.
// Assumes the controller model drives the transmit pins; short timer counts are set below.
`timescale 1ns/1ps
module phy_frame_timing_tb;
	import phy_timing_pkg::*;
	localparam int NLP = 200;
	localparam int JON = 300;
	localparam int JOFF = 500;
	logic clk = 1'b0, rst = 1'b1, speed100 = 1'b0, repeaterMode = 1'b0, carrier = 1'b0;
	logic receive_port_enable = 1'b0, rxErrIn = 1'b0, mediumReady = 1'b0, clkOn = 1'b0, enSeen = 1'b0;
	logic crs, col, txAccept, mediumActive, mediumEof, mediumValid, linkPulse, txClk, txEn, accLow;
	logic [3:0] rxNibble = 4'h0, txData, mediumData;
	logic [7:0] len = 8'h0;
	logic [2:0] offOut;
	logic [9:0] w, wq = '0;
	logic [31:0] cyc = 0, errors = 0, total_checks = 0, tTx, tOff, lpGap, lpWid, up [10], dn [10];
	logic [3:0] got [$];
	logic clkQ = 1'b0;
	rxMii_s rxOut, rxOe;
	pinIn_s pins;

	always #12.5 clk = ~clk;
	assign pins = '{txData: txData, receive_port_enable: receive_port_enable, carrier: carrier, txEn: txEn, txClk: txClk};
	assign w = {txEn, linkPulse, rxOe.er, receive_port_enable, carrier, rxOut.dv, col, mediumEof, mediumActive, crs};

	phy_frame_timing #(.NLP_PERIOD_CYC(NLP), .JAB_ON(JON), .JAB_OFF(JOFF)) DUT (.clk(clk), .rst(rst),
		.speed100(speed100), .repeaterMode(repeaterMode), .autoNegEn(1'b0), .anWord(16'h0), .pins(pins),
		.rxNibble(rxNibble), .rxErrIn(rxErrIn), .rxOut(rxOut), .rxOe(rxOe), .crs(crs), .col(col),
		.txAccept(txAccept), .mediumActive(mediumActive), .mediumEof(mediumEof), .mediumData(mediumData),
		.mediumValid(mediumValid), .mediumReady(mediumReady), .linkPulse(linkPulse));
	mii_mac_model mac (.clkOn(clkOn), .len(len), .txClk(txClk), .txEn(txEn), .txData(txData));

	// ----------------------------------------
	// Edge recorder
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (linkPulse && !wq[8])
			lpGap = cyc - up[8];
		if (!linkPulse && wq[8])
			lpWid = cyc - up[8];
		if (!rxOe.er && wq[7])
			offOut = {rxOut.clk, rxOut.dv, rxOut.er};
		for (int i = 0; i < 10; i++)
		begin
			if (w[i] && !wq[i])
				up[i] = cyc;
			if (!w[i] && wq[i])
				dn[i] = cyc;
		end
		if (txClk && !clkQ && txEn != enSeen)
		begin
			if (txEn)
				tTx = cyc;
			else
				tOff = cyc;
			enSeen = txEn;
		end
		if (!txAccept)
			accLow = 1'b1;
		if (mediumValid && mediumReady)
			got.push_back(mediumData);
		clkQ = txClk;
		wq = w;
		cyc = cyc + 1;
	end

	always @(posedge clk)
		if (cyc == 32'd20000)
		begin
			errors++;
			complete_run();
		end

	task automatic check(input string what, input logic [31:0] seen, lo, hi);
		total_checks++;
		if ((seen >= lo && seen <= hi) !== 1'b1)
		begin
			errors++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, seen);
		end
	endtask : check

	task automatic clear();
		tTx = '1;
		tOff = '1;
		accLow = 1'b0;
		got.delete();
		lpGap = '1;
		lpWid = '1;
		for (int i = 0; i < 10; i++)
		begin
			up[i] = '1;
			dn[i] = '1;
		end
	endtask : clear

	task automatic doReset(input logic fast, input logic rep);
		rst <= 1'b1;
		speed100 <= fast;
		repeaterMode <= rep;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		clear();
	endtask : doReset

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Receiver stalls through the frame, so only the two buffered nibbles may survive.
	task automatic txFrame(input logic fast);
		int c, a, e, s;
		c = (fast ? CRSON100_CYC : CRSON10_CYC) + 1;
		a = (fast ? TXST100_CYC : TXST10_CYC) + 1;
		e = (fast ? TXEND100_CYC : TXEND10_CYC) + 1;
		s = (fast ? CRSOFF100_CYC : CRSOFF10_CYC) + 1;
		doReset(fast, 1'b0);
		clkOn <= 1'b1;
		mediumReady <= 1'b0;
		len <= 8'h6;
		repeat (100) if (!txEn) @(posedge clk);
		len <= 8'h0;
		repeat (100) if (txEn) @(posedge clk);
		mediumReady <= 1'b1;
		repeat (150) @(posedge clk);
		clkOn <= 1'b0;
		check("crs on", up[0] - tTx, c + 1, c + 6);
		check("start", up[1] - tTx, a + 1, a + 6);
		check("end", dn[1] - tOff, e + 1, e + 6);
		check("crs off", dn[0] - tOff, s + 1, s + 6);
		check("stall", accLow, 1, 1);
		check("nibble0", got[0], 1, 1);
		check("nibble1", got[1], 2, 2);
		check("drained", mediumValid, 0, 0);
		if (fast)
			check("no beat", up[3], '1, '1);
		else
		begin
			check("eof width", dn[2] - up[2], 10, 10);
			check("eof start", up[2], dn[1], dn[1]);
			check("beat delay", up[3] - dn[2], HBDEL_CYC, HBDEL_CYC + 4);
			check("beat width", dn[3] - up[3], 36, 36);
		end
		$display("transmit test done");
	endtask : txFrame

	task automatic rxFrame(input logic fast);
		int c, v, f, g;
		c = (fast ? RXCRSON100_CYC : RXCRSON10_CYC) + 1;
		v = (fast ? RXDVON100_CYC : RXDVON10_CYC) + 2;
		f = (fast ? RXCRSOF100_CYC : RXCRSOF10_CYC) + 1;
		g = (fast ? RXDVOFF100_CYC : RXDVOFF10_CYC) + 2;
		doReset(fast, 1'b0);
		carrier <= 1'b1;
		rxNibble <= 4'ha;
		rxErrIn <= 1'b1;
		repeat (120) @(posedge clk);
		check("rx data", rxOut.data, 4'ha, 4'ha);
		check("rx err", rxOut.er, 1, 1);
		carrier <= 1'b0;
		rxErrIn <= 1'b0;
		repeat (60) @(posedge clk);
		check("rx crs on", up[0] - up[5], c + 1, c + 5);
		check("dv on", up[4] - up[5], v + 1, v + 5);
		check("rx crs off", dn[0] - dn[5], f + 1, f + 5);
		check("dv off", dn[4] - dn[5], g + 1, g + 5);
		$display("receive test done");
	endtask : rxFrame

	task automatic portTest();
		doReset(1'b0, 1'b1);
		check("oe reset", rxOe, 0, 0);
		clkOn <= 1'b1;
		receive_port_enable <= 1'b1;
		repeat (40) @(posedge clk);
		check("oe on", rxOe, 7'h7f, 7'h7f);
		check("drive", up[7] - up[6], 11, 21);
		receive_port_enable <= 1'b0;
		repeat (40) @(posedge clk);
		clkOn <= 1'b0;
		check("float", dn[7] - dn[6], 11, 21);
		check("low first", offOut, 0, 0);
		check("oe off", rxOe, 0, 0);
		$display("port enable test done");
	endtask : portTest

	task automatic jabTest();
		doReset(1'b0, 1'b0);
		clkOn <= 1'b1;
		mediumReady <= 1'b1;
		len <= 8'h3c;
		repeat (100) if (!txEn) @(posedge clk);
		len <= 8'h0;
		repeat (600) if (txEn) @(posedge clk);
		repeat (700) if (col) @(posedge clk);
		repeat (2) @(posedge clk);
		clkOn <= 1'b0;
		check("jab on", up[3] - up[9], JON + 1, JON + 6);
		check("cut off", dn[1] + 1 - up[3], 0, 2);
		check("jab off", dn[3] - dn[9], JOFF + 1, JOFF + 6);
		$display("jabber test done");
	endtask : jabTest

	task automatic linkTest();
		doReset(1'b0, 1'b0);
		repeat (450) @(posedge clk);
		check("pulse gap", lpGap, NLP, NLP);
		check("pulse width", lpWid, 4, 4);
		$display("link pulse test done");
	endtask : linkTest

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks != 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	initial
	begin
		clear();
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		txFrame(1'b0);
		txFrame(1'b1);
		rxFrame(1'b0);
		rxFrame(1'b1);
		portTest();
		jabTest();
		linkTest();
		complete_run();
	end
endmodule : phy_frame_timing_tb
